// ===== inc/cspc_params.svh
`ifndef CSPC_PARAMS_SVH
`define CSPC_PARAMS_SVH

`define CSPC_ADDR_W 12
`define CSPC_CTRL_BASE 12'hf00
`define CSPC_STACK_MAX 12'heff
`define CSPC_OFS_STATUS 12'hffc
`define CSPC_OFS_WINDOW 12'hffd
`define CSPC_OFS_STK_HI 12'hffe
`define CSPC_OFS_STK_LO 12'hfff
`define CSPC_BIT_C 7
`define CSPC_BIT_Z 6
`define CSPC_BIT_S 5
`define CSPC_BIT_V 4
`define CSPC_BIT_D 3
`define CSPC_BIT_H 2
`define CSPC_BIT_U2 1
`define CSPC_BIT_U1 0
`define CSPC_STATUS_RST 8'h00

`endif

// ===== inc/cspc_pkg.sv
package cspc_pkg;

    typedef enum logic [3:0] {
        CSPC_OP_NONE,
        CSPC_OP_ADD,
        CSPC_OP_SUB,
        CSPC_OP_LOGIC,
        CSPC_OP_ROT,
        CSPC_OP_SHIFT,
        CSPC_OP_BITTEST,
        CSPC_OP_CARRY_INV,
        CSPC_OP_CARRY_ZERO,
        CSPC_OP_CARRY_ONE,
        CSPC_OP_USER_SET,
        CSPC_OP_RESTORE
    } cspc_op_t;

    typedef enum logic [1:0] {
        CSPC_STK_HOLD,
        CSPC_STK_INC,
        CSPC_STK_DEC
    } cspc_stk_t;

    typedef struct packed {
        logic wrEn;
        logic rdEn;
        logic [11:0] addr;
        logic [7:0] wrData;
    } cspc_bus_t;

    typedef struct packed {
        cspc_op_t op;
        logic [7:0] opA;
        logic [7:0] opB;
        logic [7:0] result;
        logic carryIn;
        logic carryOut;
        logic [7:0] userVal;
    } cspc_alu_t;

    typedef struct packed {
        logic carry;
        logic zero;
        logic sign;
        logic ovf;
        logic decAdj;
        logic halfCarry;
        logic userTwo;
        logic userOne;
    } cspc_flags_t;

endpackage

// ===== hdl/cspc_core.sv
// Function
// - Status, window, stack high, stack low sit at FFC..FFF.
// - Register bus spans 4096 bytes; top 256 are control only.
// - Stack pointer is high byte low nibble above low byte.
// - Stack lives between 000H and EFFH; stackInRange clears once the pointer enters control region.
// - Stack steps change all 12 bits, crossing page boundaries.
// - Reset leaves both stack bytes untouched.
// - Window low nibble picks the current 256-byte page.
// - Window high nibble picks the 16-byte working group.
// - Six flags follow operations; only C, V, Z, S are jump-testable.
// - User bits change only by explicit instruction and survive reset.
// - Interrupt and traps push status; interrupt return restores it.
// - Carry follows bit 7 carry or borrow; three instructions alter it.
// - Zero set when result is 00H.
// - Sign copies result bit 7.
// - Overflow marks signed range excess; logical operations clear it.
// - Overflow from add, subtract and rotate sign rules.
// - Decimal-adjust flag set by subtract, cleared by add.
// - Half-carry from bit 3 carry or bit 4 borrow.
// - Condition code comes from opcode bits 7:4.
// - Codes 0..7: never, S^V, Z|(S^V), C|Z, V, S, Z, C.
// - Codes 8..F are the negations, with 8 always.
// - Multi-byte values are big-endian.
`include "cspc_params.svh"

module cspc_core
    import cspc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Register bus.
    input wire cspc_bus_t regBus,
    output logic [7:0] rdData,
    output logic rdHit,
    output logic ctrlRegion,
    // Flag update from the execution datapath.
    input wire cspc_alu_t alu,
    // Stack control.
    input wire cspc_stk_t stkOp,
    output logic [11:0] stackPtr,
    output logic stackInRange,
    // Status save for interrupts and traps.
    input wire logic saveStatus,
    output logic [7:0] statusPushData,
    output logic statusPushValid,
    // Window pointer decode.
    input wire logic [3:0] workRegNum,
    output logic [3:0] curPage,
    output logic [3:0] curGroup,
    output logic [11:0] workRegAddr,
    // Condition evaluation.
    input wire logic [7:0] jumpOpcode,
    output logic jumpTaken,
    // Whole status byte.
    output cspc_flags_t flags
);

    localparam logic [7:0] STATUS_RST = `CSPC_STATUS_RST;

    logic [7:0] windowReg;
    logic [7:0] stkHiReg;
    logic [7:0] stkLoReg;
    logic [5:0] opFlagReg;
    logic [5:0] opFlagNext;
    logic [1:0] userReg;
    logic [1:0] userNext;
    logic [11:0] spCur;
    logic [11:0] spNext;
    logic [8:0] sum9;
    logic [4:0] nib5;
    logic fc;
    logic fz;
    logic fs;
    logic fv;
    logic fd;
    logic fh;
    logic [3:0] cond;
    logic sxv;
    logic condRaw;
    logic wrStatus;
    logic wrWindow;
    logic wrStkHi;
    logic wrStkLo;
    logic [7:0] statusByte;

    // One exact address comparator per control register write.
    cspc_addr_match #(
        .MATCH_ADDR(`CSPC_OFS_STATUS)
    ) status_wr_u (
        .strobe(regBus.wrEn),
        .addr(regBus.addr),
        .hit(wrStatus)
    );

    cspc_addr_match #(
        .MATCH_ADDR(`CSPC_OFS_WINDOW)
    ) window_wr_u (
        .strobe(regBus.wrEn),
        .addr(regBus.addr),
        .hit(wrWindow)
    );

    cspc_addr_match #(
        .MATCH_ADDR(`CSPC_OFS_STK_HI)
    ) stk_hi_wr_u (
        .strobe(regBus.wrEn),
        .addr(regBus.addr),
        .hit(wrStkHi)
    );

    cspc_addr_match #(
        .MATCH_ADDR(`CSPC_OFS_STK_LO)
    ) stk_lo_wr_u (
        .strobe(regBus.wrEn),
        .addr(regBus.addr),
        .hit(wrStkLo)
    );

    assign ctrlRegion = regBus.addr >= `CSPC_CTRL_BASE;

    // Flag computation from the datapath operation.
    always_comb begin
        sum9 = 9'h000;
        nib5 = 5'h00;
        fc = opFlagReg[5];
        fz = opFlagReg[4];
        fs = opFlagReg[3];
        fv = opFlagReg[2];
        fd = opFlagReg[1];
        fh = opFlagReg[0];
        case (alu.op)
            CSPC_OP_ADD: begin
                sum9 = {1'b0, alu.opA} + {1'b0, alu.opB} + {8'h00, alu.carryIn};
                nib5 = {1'b0, alu.opA[3:0]} + {1'b0, alu.opB[3:0]} + {4'h0, alu.carryIn};
                fc = sum9[8];
                fz = sum9[7:0] == 8'h00;
                fs = sum9[7];
                fv = (alu.opA[7] == alu.opB[7]) && (sum9[7] != alu.opA[7]);
                fd = 1'b0;
                fh = nib5[4];
            end
            CSPC_OP_SUB: begin
                // Destination opA minus source opB.
                sum9 = {1'b0, alu.opA} - {1'b0, alu.opB} - {8'h00, alu.carryIn};
                nib5 = {1'b0, alu.opA[3:0]} - {1'b0, alu.opB[3:0]} - {4'h0, alu.carryIn};
                fc = sum9[8];
                fz = sum9[7:0] == 8'h00;
                fs = sum9[7];
                fv = (alu.opA[7] != alu.opB[7]) && (sum9[7] == alu.opB[7]);
                fd = 1'b1;
                fh = nib5[4];
            end
            CSPC_OP_LOGIC: begin
                fz = alu.result == 8'h00;
                fs = alu.result[7];
                fv = 1'b0;
            end
            CSPC_OP_ROT: begin
                fc = alu.carryOut;
                fz = alu.result == 8'h00;
                fs = alu.result[7];
                fv = alu.result[7] != alu.opA[7];
            end
            CSPC_OP_SHIFT: begin
                fc = alu.carryOut;
                fz = alu.result == 8'h00;
                fs = alu.result[7];
                fv = alu.result[7] != alu.opA[7];
            end
            CSPC_OP_BITTEST: begin
                fz = alu.result == 8'h00;
            end
            CSPC_OP_CARRY_INV: begin
                fc = ~opFlagReg[5];
            end
            CSPC_OP_CARRY_ZERO: begin
                fc = 1'b0;
            end
            CSPC_OP_CARRY_ONE: begin
                fc = 1'b1;
            end
            CSPC_OP_RESTORE: begin
                {fc, fz, fs, fv, fd, fh} = alu.userVal[7:2];
            end
            default: begin
                fc = opFlagReg[5];
            end
        endcase
        opFlagNext = {fc, fz, fs, fv, fd, fh};
    end

    // User bits: only an explicit load or a status restore changes them.
    always_comb begin
        userNext = userReg;
        if (alu.op == CSPC_OP_USER_SET || alu.op == CSPC_OP_RESTORE) begin
            userNext = alu.userVal[1:0];
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            opFlagReg <= STATUS_RST[7:2];
        end else if (wrStatus) begin
            opFlagReg <= regBus.wrData[7:2];
        end else begin
            opFlagReg <= opFlagNext;
        end
    end

    // User bits are outside reset on purpose.
    always_ff @(posedge mclk) begin
        if (wrStatus) begin
            userReg <= regBus.wrData[1:0];
        end else begin
            userReg <= userNext;
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            windowReg <= 8'h00;
        end else if (wrWindow) begin
            windowReg <= regBus.wrData;
        end
    end

    assign spCur = {stkHiReg[3:0], stkLoReg};

    always_comb begin
        case (stkOp)
            CSPC_STK_INC: begin
                spNext = spCur + 12'h001;
            end
            CSPC_STK_DEC: begin
                spNext = spCur - 12'h001;
            end
            default: begin
                spNext = spCur;
            end
        endcase
    end

    // Stack bytes carry no reset; software must load them first.
    always_ff @(posedge mclk) begin
        if (wrStkHi) begin
            stkHiReg <= regBus.wrData;
        end else if (stkOp != CSPC_STK_HOLD) begin
            stkHiReg <= {stkHiReg[7:4], spNext[11:8]};
        end
    end

    always_ff @(posedge mclk) begin
        if (wrStkLo) begin
            stkLoReg <= regBus.wrData;
        end else if (stkOp != CSPC_STK_HOLD) begin
            stkLoReg <= spNext[7:0];
        end
    end

    assign stackPtr = spCur;
    assign stackInRange = spCur <= `CSPC_STACK_MAX;

    assign statusByte = {opFlagReg, userReg};
    assign flags = statusByte;

    // Status push: registered copy of the byte at the save request.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            statusPushData <= 8'h00;
            statusPushValid <= 1'b0;
        end else begin
            statusPushValid <= saveStatus;
            if (saveStatus) begin
                statusPushData <= statusByte;
            end
        end
    end

    assign curPage = windowReg[3:0];
    assign curGroup = windowReg[7:4];
    assign workRegAddr = {windowReg[3:0], windowReg[7:4], workRegNum};

    // Condition evaluation on C, Z, S, V only.
    assign cond = jumpOpcode[7:4];
    assign sxv = opFlagReg[3] ^ opFlagReg[2];

    always_comb begin
        case (cond[2:0])
            3'h0: condRaw = 1'b0;
            3'h1: condRaw = sxv;
            3'h2: condRaw = opFlagReg[4] | sxv;
            3'h3: condRaw = opFlagReg[5] | opFlagReg[4];
            3'h4: condRaw = opFlagReg[2];
            3'h5: condRaw = opFlagReg[3];
            3'h6: condRaw = opFlagReg[4];
            3'h7: condRaw = opFlagReg[5];
            default: condRaw = 1'b0;
        endcase
    end

    assign jumpTaken = cond[3] ^ condRaw;

    // Register read, registered one cycle after the strobe.
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdData <= 8'h00;
            rdHit <= 1'b0;
        end else begin
            rdHit <= 1'b0;
            rdData <= 8'h00;
            if (regBus.rdEn) begin
                case (regBus.addr)
                    `CSPC_OFS_STATUS: begin
                        rdData <= statusByte;
                        rdHit <= 1'b1;
                    end
                    `CSPC_OFS_WINDOW: begin
                        rdData <= windowReg;
                        rdHit <= 1'b1;
                    end
                    `CSPC_OFS_STK_HI: begin
                        rdData <= stkHiReg;
                        rdHit <= 1'b1;
                    end
                    `CSPC_OFS_STK_LO: begin
                        rdData <= stkLoReg;
                        rdHit <= 1'b1;
                    end
                    default: begin
                        rdData <= 8'h00;
                    end
                endcase
            end
        end
    end

endmodule

// Flags a strobe aimed at one fixed register address.
module cspc_addr_match
    import cspc_pkg::*;
#(
    parameter logic [11:0] MATCH_ADDR = 12'h000
) (
    // Request.
    input wire logic strobe,
    input wire logic [11:0] addr,
    // Result.
    output logic hit
);

    assign hit = strobe && addr == MATCH_ADDR;

endmodule

// ===== tb/cspc_core_assertions.sv
module cspc_core_chk
    import cspc_pkg::*;
(
    // Clock and reset.
    input wire logic mclk,
    input wire logic sys_rst,
    // Register bus.
    input wire cspc_bus_t regBus,
    input wire logic [7:0] rdData,
    input wire logic rdHit,
    input wire logic ctrlRegion,
    // Datapath.
    input wire cspc_alu_t alu,
    input wire cspc_stk_t stkOp,
    input wire logic [11:0] stackPtr,
    input wire logic stackInRange,
    input wire logic saveStatus,
    input wire logic [7:0] statusPushData,
    input wire logic statusPushValid,
    input wire logic [7:0] jumpOpcode,
    input wire logic jumpTaken,
    input wire cspc_flags_t flags
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // Stack and user bits hold unknowns until software has loaded them.
    logic [2:0] seen_reg;
    logic seeded;
    logic [7:0] resQ_reg;
    logic stWr;
    assign stWr = regBus.wrEn && regBus.addr == 12'hffc;
    assign seeded = &seen_reg;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            seen_reg <= 3'h0;
        end else begin
            seen_reg <= seen_reg | {stWr, regBus.wrEn && regBus.addr == 12'hffe,
                regBus.wrEn && regBus.addr == 12'hfff};
        end
    end
    // Expected add result, worked out from the operands alone.
    always_ff @(posedge mclk) begin
        resQ_reg <= alu.opA + alu.opB + {7'h00, alu.carryIn};
    end
    sequence s_rd_ctrl;
        regBus.rdEn && regBus.addr >= 12'hffc;
    endsequence
    property p_rd_hit; s_rd_ctrl |=> rdHit; endproperty
    a_rd_hit: assert property (p_rd_hit) else $error("control read not answered");
    property p_rd_miss;
        regBus.rdEn && regBus.addr < 12'hffc |=> !rdHit && rdData == 8'h00;
    endproperty
    a_rd_miss: assert property (p_rd_miss) else $error("other address answered");
    property p_ctrl; ctrlRegion == (regBus.addr >= 12'hf00); endproperty
    a_ctrl: assert property (p_ctrl) else $error("control region decode wrong");
    property p_range; seeded |-> stackInRange == (stackPtr <= 12'heff); endproperty
    a_range: assert property (p_range) else $error("stack range flag wrong");
    property p_step;
        seeded && stkOp != CSPC_STK_HOLD && !regBus.wrEn |=> stackPtr ==
            $past(stackPtr) + (($past(stkOp) == CSPC_STK_INC) ? 12'h001 : 12'hfff);
    endproperty
    a_step: assert property (p_step) else $error("stack step wrong");
    property p_push; saveStatus |=> statusPushValid && statusPushData == $past(flags); endproperty
    a_push: assert property (p_push) else $error("status push wrong");
    property p_add;
        alu.op == CSPC_OP_ADD && !stWr |=>
            flags.zero == (resQ_reg == 8'h00) && flags.sign == resQ_reg[7] && !flags.decAdj;
    endproperty
    a_add: assert property (p_add) else $error("add flags wrong");
    property p_logic; alu.op == CSPC_OP_LOGIC && !stWr |=> !flags.ovf; endproperty
    a_logic: assert property (p_logic) else $error("logic left overflow set");
    property p_user;
        seeded && !stWr && !(alu.op inside {CSPC_OP_USER_SET, CSPC_OP_RESTORE}) |=>
            $stable({flags.userTwo, flags.userOne});
    endproperty
    a_user: assert property (p_user) else $error("user bits changed");
    property p_wr; stWr |=> flags == $past(regBus.wrData); endproperty
    a_wr: assert property (p_wr) else $error("status write lost");
    property p_jump; jumpOpcode[6:4] == 3'h7 |-> jumpTaken == (flags.carry ^ jumpOpcode[7]); endproperty
    a_jump: assert property (p_jump) else $error("carry jump wrong");
endmodule

bind cspc_core cspc_core_chk chk_u (
    .mclk, .sys_rst, .regBus, .rdData, .rdHit, .ctrlRegion, .alu, .stkOp, .stackPtr,
    .stackInRange, .saveStatus, .statusPushData, .statusPushValid, .jumpOpcode, .jumpTaken, .flags
);

// ===== tb/tb.sv
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cspc_pkg::*;
    logic mclk = 1'b0;
    logic sys_rst = 1'b1;
    logic saveStatus = 1'b0;
    cspc_bus_t regBus = '0;
    cspc_alu_t alu = '0;
    cspc_stk_t stkOp = CSPC_STK_HOLD;
    logic [3:0] workRegNum = 4'h5;
    logic [7:0] jumpOpcode = 8'h00;
    logic [7:0] rdData, statusPushData;
    logic rdHit, ctrlRegion, stackInRange, statusPushValid, jumpTaken;
    logic [11:0] stackPtr, workRegAddr;
    logic [3:0] curPage, curGroup;
    cspc_flags_t flags;
    int fail_count = 0;
    int compares = 0;
    logic [7:0] fs [4] = '{8'hf3, 8'h0c, 8'h92, 8'h61};
    always #10 mclk = ~mclk;
    cspc_core dut_u (
        .mclk, .sys_rst, .regBus, .rdData, .rdHit, .ctrlRegion, .alu, .stkOp, .stackPtr,
        .stackInRange, .saveStatus, .statusPushData, .statusPushValid, .workRegNum,
        .curPage, .curGroup, .workRegAddr, .jumpOpcode, .jumpTaken, .flags
    );
    task automatic tick();
        @(posedge mclk);
        #1;
    endtask
    task automatic chk(logic [11:0] got, logic [11:0] exp);
        compares++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic bus(logic w, logic r, logic [11:0] a, logic [7:0] d);
        regBus = '{w, r, a, d};
        tick();
    endtask
    task automatic rd(logic [11:0] a, logic [7:0] e, logic h);
        bus(1'b0, 1'b1, a, 8'h00);
        chk(12'(rdData), 12'(e));
        chk(12'(rdHit), 12'(h));
    endtask
    task automatic op(cspc_op_t o, logic [7:0] a, logic [7:0] r, logic [7:0] m, logic [7:0] e);
        alu = '{o, a, 8'h01, r, 1'b0, 1'b0, r};
        tick();
        alu.op = CSPC_OP_NONE;
        tick();
        chk(12'(flags & m), 12'(e));
    endtask
    function automatic logic jexp(logic [3:0] cc, cspc_flags_t f);
        logic sv;
        logic t;
        sv = f.sign ^ f.ovf;
        case (cc[2:0])
            3'h0: t = 1'b0;
            3'h1: t = sv;
            3'h2: t = f.zero | sv;
            3'h3: t = f.carry | f.zero;
            3'h4: t = f.ovf;
            3'h5: t = f.sign;
            3'h6: t = f.zero;
            default: t = f.carry;
        endcase
        return t ^ cc[3];
    endfunction
    task automatic close_out();
        $display("Comparisons %0d, mismatches %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    initial begin
        #40000;
        fail_count++;
        close_out();
    end
    initial begin
        repeat (20) @(posedge mclk);
        #1;
        sys_rst = 1'b0;
        bus(1'b1, 1'b0, 12'hffc, 8'h03);
        bus(1'b1, 1'b0, 12'hffd, 8'h7c);
        bus(1'b1, 1'b0, 12'hffe, 8'ha1);
        bus(1'b1, 1'b0, 12'hfff, 8'hff);
        rd(12'hffc, 8'h03, 1'b1);
        rd(12'hffd, 8'h7c, 1'b1);
        chk(12'(ctrlRegion), 12'h001);
        rd(12'hf00, 8'h00, 1'b0);
        rd(12'h123, 8'h00, 1'b0);
        chk(12'(ctrlRegion), 12'h000);
        chk(stackPtr, 12'h1ff);
        chk(workRegAddr, 12'hc75);
        chk({curGroup, curPage, 4'h0}, 12'h7c0);
        $display("Registers test done");
        stkOp = CSPC_STK_INC;
        tick();
        chk(stackPtr, 12'h200);
        stkOp = CSPC_STK_DEC;
        tick();
        tick();
        chk(stackPtr, 12'h1fe);
        stkOp = CSPC_STK_HOLD;
        rd(12'hffe, 8'ha1, 1'b1);
        bus(1'b1, 1'b0, 12'hffe, 8'h0e);
        chk(12'(stackInRange), 12'h001);
        stkOp = CSPC_STK_INC;
        bus(1'b0, 1'b0, 12'h000, 8'h00);
        chk(stackPtr, 12'heff);
        chk(12'(stackInRange), 12'h001);
        tick();
        stkOp = CSPC_STK_HOLD;
        chk(stackPtr, 12'hf00);
        chk(12'(stackInRange), 12'h000);
        $display("Stack test done");
        op(CSPC_OP_ADD, 8'h7f, 8'h80, 8'hff, 8'h37);
        op(CSPC_OP_SUB, 8'h00, 8'hff, 8'hff, 8'haf);
        op(CSPC_OP_SUB, 8'h80, 8'h7f, 8'hff, 8'h1f);
        op(CSPC_OP_LOGIC, 8'h0f, 8'h00, 8'h7f, 8'h4f);
        op(CSPC_OP_CARRY_ONE, 8'h00, 8'h00, 8'hff, 8'hcf);
        op(CSPC_OP_CARRY_ZERO, 8'h00, 8'h00, 8'hff, 8'h4f);
        op(CSPC_OP_CARRY_INV, 8'h00, 8'h00, 8'hff, 8'hcf);
        op(CSPC_OP_BITTEST, 8'h01, 8'h01, 8'hff, 8'h8f);
        op(CSPC_OP_ROT, 8'h40, 8'h80, 8'hff, 8'h3f);
        op(CSPC_OP_SHIFT, 8'h80, 8'h00, 8'hff, 8'h5f);
        op(CSPC_OP_USER_SET, 8'h00, 8'h02, 8'hff, 8'h5e);
        op(CSPC_OP_RESTORE, 8'h00, 8'h5a, 8'hff, 8'h5a);
        saveStatus = 1'b1;
        tick();
        saveStatus = 1'b0;
        chk({statusPushValid, 3'h0, statusPushData}, 12'h85a);
        alu = '{CSPC_OP_ADD, 8'h7f, 8'h01, 8'h80, 1'b0, 1'b0, 8'h00};
        bus(1'b1, 1'b0, 12'hffc, 8'h81);
        alu.op = CSPC_OP_NONE;
        bus(1'b0, 1'b0, 12'h000, 8'h00);
        chk(12'(flags), 12'h081);
        $display("Flags test done");
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, 1'b0, 12'hffc, fs[i]);
            for (int c = 0; c < 16; c++) begin
                jumpOpcode = {4'(c), 4'h3};
                tick();
                chk(12'(jumpTaken), 12'(jexp(4'(c), fs[i])));
            end
        end
        $display("Jump test done");
        bus(1'b0, 1'b0, 12'h000, 8'h00);
        sys_rst = 1'b1;
        tick();
        sys_rst = 1'b0;
        chk(12'(flags), 12'h001);
        chk(stackPtr, 12'hf00);
        rd(12'hffd, 8'h00, 1'b1);
        $display("Reset test done");
        close_out();
    end
endmodule
